//--- shared/pcm_regs.svh
`ifndef PCM_REGS_SVH
`define PCM_REGS_SVH
// Byte addresses
`define PCM_ADDR_POWER_CONTROL 12'h1c4
`define PCM_ADDR_EVENT_FLAGS 12'h1c8
`define PCM_ADDR_WAKE_ENABLE 12'h1cc
`define PCM_ADDR_MEMORY_CONTROL 12'h1d0
// Power control fields
`define PCM_PC_BUTTON 31
`define PCM_PC_IRQ_PIN 30
`define PCM_PC_POWER_GOOD 29
`define PCM_PC_VIDEO_HI 28
`define PCM_PC_VIDEO_LO 27
`define PCM_PC_HALF_SPEED 26
`define PCM_PC_DECOUPLE 25
`define PCM_PC_LIMIT_HI 15
`define PCM_PC_LIMIT_LO 12
`define PCM_PC_TIMER_EN 11
`define PCM_PC_CUTOFF_EN 10
`define PCM_PC_CUTOFF_PEND 9
`define PCM_PC_CUTOFF_OCC 8
`define PCM_PC_SHORT_SETTLE 7
`define PCM_PC_BYPASS 5
`define PCM_PC_HALT 4
`define PCM_PC_DEBOUNCE 3
`define PCM_PC_POR_SEEN 2
`define PCM_PC_SUPPLY_EN 1
`define PCM_PC_CORE_ON 0
`define PCM_MEM_SLEEP_BIT 0
`define PCM_NUM_FLAGS 7
// Reset values
`define PCM_RST_ZERO 32'h0000_0000
`define PCM_RST_POR_SEEN 1'b1
`define PCM_RST_LIMIT 4'h0
// Timer
`define PCM_TIMER_MAX 4'hf
`define PCM_TIMER_STEP 4'h1
// Times in ms and tick periods
`define PCM_TICK_2MS_MS 2
`define PCM_TICK_8MS_MS 8
`define PCM_SETTLE_SHORT_MIN_MS 4
`define PCM_SETTLE_LONG_MIN_MS 16
`define PCM_DEBOUNCE_MIN_MS 16
// Tick counts: first tick lands anywhere within one period, so min/period + 1
`define PCM_SETTLE_SHORT_TICKS 2'((`PCM_SETTLE_SHORT_MIN_MS / `PCM_TICK_2MS_MS) + 1)
`define PCM_SETTLE_LONG_TICKS 2'((`PCM_SETTLE_LONG_MIN_MS / `PCM_TICK_8MS_MS) + 1)
`define PCM_DEBOUNCE_TICKS 2'((`PCM_DEBOUNCE_MIN_MS / `PCM_TICK_8MS_MS) + 1)
`define PCM_CNT_STEP 2'h1
// AXI responses
`define PCM_RESP_OKAY 2'h0
`define PCM_RESP_SLVERR 2'h2
`endif

//--- shared/pcm_pkg.sv
`default_nettype none
package pcm_pkg;
	typedef struct packed {
		logic on_button;
		logic power_irq_pin;
		logic power_good;
	} pcm_pins_t;
	typedef struct packed {
		logic sys_clock_en;
		logic core_clock_en;
		logic bus_clock_en;
		logic video_clock_en;
		logic peripheral_clock_decouple;
	} pcm_clk_t;
	typedef enum logic [2:0] {
		FLAG_WAKE_TIMER,
		FLAG_IRQ_RISE,
		FLAG_IRQ_FALL,
		FLAG_GOOD_RISE,
		FLAG_GOOD_FALL,
		FLAG_BUTTON_RISE,
		FLAG_BUTTON_FALL
	} pcm_flag_t;
endpackage
`default_nettype wire

//--- rtl/pcm_top.sv
// Notes on behaviour
// [RULE1] Sleep request drives memory pins low and puts dynamic memory in self-refresh.
// [RULE2] First access outside cache and internal registers clears the sleep request.
// [RULE3] Wake timer is a 4-bit up counter held at zero while disabled.
// [RULE4] Enabled wake timer counts one per 8 ms tick, at most fifteen steps.
// [RULE5] Wake timer flag sets when enabled count equals the programmed limit.
// [RULE6] Power interrupt pin rise and fall each set their own flag.
// [RULE7] Power good rise and fall each set their own flag.
// [RULE8] Button rise and fall flagged separately; debounce waits 16 to 24 ms stable.
// [RULE9] Bits 31..29 read live button, interrupt pin and power good levels.
// [RULE10] Video ratio field divides video master clock by 1, 2, 4 or 8.
// [RULE11] Half-speed bit halves internal clocks except free-running and oscillator clocks.
// [RULE12] Decouple bit frees peripheral clocks from the core clock ratio.
// [RULE13] Cutoff pending sets whenever a wake event raises both supply bits.
// [RULE14] Enabled cutoff with pending set and power good falling drops both supplies.
// [RULE15] Cutoff occurred bit sets on a forced cutoff; software clears it after.
// [RULE16] System clock gated 4-6 ms or 16-24 ms after core supply rises.
// [RULE17] Bypass bit enables system clock as soon as core supply is on.
// [RULE18] Halt bit gates core clock; any enabled flag setting clears it.
// [RULE19] Debounce bit delays button flags and wake; else immediate on transition.
// [RULE20] Power-on reset seen bit resets to one.
// [RULE21] Button press or enabled flag with power good high sets both supply bits.
// [RULE22] Supply bits stay high while any enabled flag is pending.
// [RULE23] Enabled flag latched while power good low powers up once it rises.
// [RULE24] Each event flag stays set until software clears it.
`timescale 1ns/1ns
`default_nettype none
`include "pcm_regs.svh"
module pcm_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire pcm_pkg::pcm_pins_t pins,
	input wire logic tick_2ms,
	input wire logic tick_8ms,
	input wire logic video_master_clock,
	input wire logic external_access,
	output pcm_pkg::pcm_clk_t clocks,
	output logic supply_enable_out,
	output logic core_supply_rail,
	output logic memory_sleep_request
);
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic mapped(input logic [11:0] a);
		return (a == `PCM_ADDR_POWER_CONTROL) || (a == `PCM_ADDR_EVENT_FLAGS) ||
			(a == `PCM_ADDR_WAKE_ENABLE) || (a == `PCM_ADDR_MEMORY_CONTROL);
	endfunction

	// Write channel capture
	logic aw_have_q, w_have_q;
	logic [11:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic wr_fire;
	assign s_axi_awready = !aw_have_q;
	assign s_axi_wready = !w_have_q;
	assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			awaddr_q <= 12'h000;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_have_q <= 1'b1;
			awaddr_q <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_have_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_have_q <= 1'b0;
			wdata_q <= `PCM_RST_ZERO;
			wstrb_q <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_have_q <= 1'b1;
			wdata_q <= s_axi_wdata;
			wstrb_q <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_have_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `PCM_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= mapped(awaddr_q) ? `PCM_RESP_OKAY : `PCM_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Register state
	logic [31:0] pc_q, pc_m, flag_m, en_m;
	logic [`PCM_NUM_FLAGS-1:0] flags_q, enable_q, events, clr;
	logic wr_pc, wr_flags, wr_en, wr_mem, pend_any, wake_now;
	assign wr_pc = wr_fire && (awaddr_q == `PCM_ADDR_POWER_CONTROL);
	assign wr_flags = wr_fire && (awaddr_q == `PCM_ADDR_EVENT_FLAGS);
	assign wr_en = wr_fire && (awaddr_q == `PCM_ADDR_WAKE_ENABLE);
	assign wr_mem = wr_fire && (awaddr_q == `PCM_ADDR_MEMORY_CONTROL);
	assign pc_m = merge(pc_q, wdata_q, wstrb_q);
	assign flag_m = merge(`PCM_RST_ZERO, wdata_q, wstrb_q);
	assign en_m = merge({25'h000_0000, enable_q}, wdata_q, wstrb_q);
	assign clr = wr_flags ? flag_m[`PCM_NUM_FLAGS-1:0] : '0;
	assign pend_any = |(flags_q & enable_q);
	assign wake_now = |(events & enable_q);

	// Input history and edges
	logic irq_prev_q, good_prev_q, btn_raw_q, btn_db_q, btn_prev_q;
	logic [1:0] db_cnt_q;
	logic good_fall;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_prev_q <= 1'b0;
			good_prev_q <= 1'b0;
			btn_raw_q <= 1'b0;
			btn_prev_q <= 1'b0;
		end else begin
			irq_prev_q <= pins.power_irq_pin;
			good_prev_q <= pins.power_good;
			btn_raw_q <= pins.on_button;
			btn_prev_q <= btn_db_q;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			btn_db_q <= 1'b0;
			db_cnt_q <= 2'h0;
		end else if (!pc_q[`PCM_PC_DEBOUNCE]) begin
			btn_db_q <= btn_raw_q; // RULE19
			db_cnt_q <= 2'h0;
		end else if (btn_raw_q == btn_db_q) begin
			db_cnt_q <= 2'h0;
		end else if (tick_8ms) begin
			if (db_cnt_q + `PCM_CNT_STEP == `PCM_DEBOUNCE_TICKS) begin
				btn_db_q <= btn_raw_q; // RULE8 RULE19
				db_cnt_q <= 2'h0;
			end else begin
				db_cnt_q <= db_cnt_q + `PCM_CNT_STEP;
			end
		end
	end

	// Wake timer
	logic [3:0] timer_q;
	logic match_q, match;
	assign match = pc_q[`PCM_PC_TIMER_EN] && (timer_q == pc_q[`PCM_PC_LIMIT_HI:`PCM_PC_LIMIT_LO]);
	always_ff @(posedge aclk) begin
		if (!aresetn || !pc_q[`PCM_PC_TIMER_EN]) begin
			timer_q <= 4'h0; // RULE3
		end else if (tick_8ms && timer_q != `PCM_TIMER_MAX) begin
			timer_q <= timer_q + `PCM_TIMER_STEP; // RULE4
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			match_q <= 1'b0;
		end else begin
			match_q <= match;
		end
	end

	assign good_fall = good_prev_q && !pins.power_good;
	always_comb begin
		events = '0;
		events[pcm_pkg::FLAG_WAKE_TIMER] = match && !match_q; // RULE5
		events[pcm_pkg::FLAG_IRQ_RISE] = !irq_prev_q && pins.power_irq_pin; // RULE6
		events[pcm_pkg::FLAG_IRQ_FALL] = irq_prev_q && !pins.power_irq_pin; // RULE6
		events[pcm_pkg::FLAG_GOOD_RISE] = !good_prev_q && pins.power_good; // RULE7
		events[pcm_pkg::FLAG_GOOD_FALL] = good_fall; // RULE7
		events[pcm_pkg::FLAG_BUTTON_RISE] = btn_db_q && !btn_prev_q; // RULE8
		events[pcm_pkg::FLAG_BUTTON_FALL] = !btn_db_q && btn_prev_q; // RULE8
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags_q <= '0;
			enable_q <= '0;
		end else begin
			flags_q <= (flags_q & ~clr) | events; // RULE24
			if (wr_en) begin
				enable_q <= en_m[`PCM_NUM_FLAGS-1:0];
			end
		end
	end

	// Supply sequencing
	logic power_up, cutoff;
	assign power_up = !pc_q[`PCM_PC_CORE_ON] && pins.power_good &&
		(events[pcm_pkg::FLAG_BUTTON_RISE] || pend_any); // RULE21 RULE23
	assign cutoff = pc_q[`PCM_PC_CUTOFF_EN] && pc_q[`PCM_PC_CUTOFF_PEND] &&
		pc_q[`PCM_PC_CORE_ON] && good_fall; // RULE14

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pc_q <= `PCM_RST_ZERO;
			pc_q[`PCM_PC_POR_SEEN] <= `PCM_RST_POR_SEEN; // RULE20
		end else begin
			if (wr_pc) begin
				pc_q[`PCM_PC_VIDEO_HI:`PCM_PC_DECOUPLE] <= pc_m[`PCM_PC_VIDEO_HI:`PCM_PC_DECOUPLE];
				pc_q[`PCM_PC_LIMIT_HI:`PCM_PC_SHORT_SETTLE] <= pc_m[`PCM_PC_LIMIT_HI:`PCM_PC_SHORT_SETTLE];
				pc_q[`PCM_PC_BYPASS:`PCM_PC_POR_SEEN] <= pc_m[`PCM_PC_BYPASS:`PCM_PC_POR_SEEN];
				pc_q[`PCM_PC_SUPPLY_EN] <= pc_m[`PCM_PC_SUPPLY_EN] || pend_any; // RULE22
				pc_q[`PCM_PC_CORE_ON] <= pc_m[`PCM_PC_CORE_ON] || pend_any; // RULE22
			end
			if (wake_now) begin
				pc_q[`PCM_PC_HALT] <= 1'b0; // RULE18
			end
			if (cutoff) begin
				pc_q[`PCM_PC_SUPPLY_EN] <= 1'b0; // RULE14
				pc_q[`PCM_PC_CORE_ON] <= 1'b0;
				pc_q[`PCM_PC_CUTOFF_OCC] <= 1'b1; // RULE15
			end
			if (power_up) begin
				pc_q[`PCM_PC_SUPPLY_EN] <= 1'b1; // RULE21
				pc_q[`PCM_PC_CORE_ON] <= 1'b1;
				pc_q[`PCM_PC_CUTOFF_PEND] <= 1'b1; // RULE13
			end
		end
	end

	// Clock settle after core supply rises
	logic core_prev_q, settled_q, settle_tick;
	logic [1:0] settle_cnt_q, settle_target;
	assign settle_tick = pc_q[`PCM_PC_SHORT_SETTLE] ? tick_2ms : tick_8ms;
	assign settle_target = pc_q[`PCM_PC_SHORT_SETTLE] ? `PCM_SETTLE_SHORT_TICKS : `PCM_SETTLE_LONG_TICKS;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			core_prev_q <= 1'b0;
			settled_q <= 1'b0;
			settle_cnt_q <= 2'h0;
		end else begin
			core_prev_q <= pc_q[`PCM_PC_CORE_ON];
			if (!pc_q[`PCM_PC_CORE_ON]) begin
				settled_q <= 1'b0;
				settle_cnt_q <= 2'h0;
			end else if (!settled_q && settle_tick) begin
				if (settle_cnt_q + `PCM_CNT_STEP == settle_target) begin
					settled_q <= 1'b1; // RULE16
				end
				settle_cnt_q <= settle_cnt_q + `PCM_CNT_STEP;
			end
		end
	end

	// Clock enables
	logic half_q, video_en_q;
	logic [2:0] video_cnt_q, video_mask;
	assign video_mask = 3'((4'h1 << pc_q[`PCM_PC_VIDEO_HI:`PCM_PC_VIDEO_LO]) - 4'h1);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			half_q <= 1'b0;
			video_cnt_q <= 3'h0;
			video_en_q <= 1'b0;
		end else begin
			half_q <= !half_q;
			video_en_q <= video_master_clock && ((video_cnt_q & video_mask) == 3'h0); // RULE10
			if (video_master_clock) begin
				video_cnt_q <= video_cnt_q + 3'h1;
			end
		end
	end
	assign clocks.sys_clock_en = pc_q[`PCM_PC_CORE_ON] && (settled_q || pc_q[`PCM_PC_BYPASS]); // RULE16 RULE17
	assign clocks.core_clock_en = clocks.sys_clock_en && !pc_q[`PCM_PC_HALT] &&
		(!pc_q[`PCM_PC_HALF_SPEED] || half_q); // RULE18 RULE11
	assign clocks.bus_clock_en = clocks.sys_clock_en && (!pc_q[`PCM_PC_HALF_SPEED] || half_q); // RULE11
	assign clocks.video_clock_en = video_en_q;
	assign clocks.peripheral_clock_decouple = pc_q[`PCM_PC_DECOUPLE]; // RULE12
	assign supply_enable_out = pc_q[`PCM_PC_SUPPLY_EN];
	assign core_supply_rail = pc_q[`PCM_PC_CORE_ON];

	// Memory sleep request
	logic mem_sleep_q;
	always_ff @(posedge aclk) begin
		if (!aresetn || external_access) begin
			mem_sleep_q <= 1'b0; // RULE2
		end else if (wr_mem) begin
			mem_sleep_q <= flag_m[`PCM_MEM_SLEEP_BIT]; // RULE1
		end
	end
	assign memory_sleep_request = mem_sleep_q; // RULE1

	// Read channel
	logic [31:0] rd_val;
	always_comb begin
		rd_val = `PCM_RST_ZERO;
		if (s_axi_araddr == `PCM_ADDR_POWER_CONTROL) begin
			rd_val = pc_q;
			rd_val[`PCM_PC_BUTTON] = pins.on_button; // RULE9
			rd_val[`PCM_PC_IRQ_PIN] = pins.power_irq_pin;
			rd_val[`PCM_PC_POWER_GOOD] = pins.power_good;
		end else if (s_axi_araddr == `PCM_ADDR_EVENT_FLAGS) begin
			rd_val[`PCM_NUM_FLAGS-1:0] = flags_q;
		end else if (s_axi_araddr == `PCM_ADDR_WAKE_ENABLE) begin
			rd_val[`PCM_NUM_FLAGS-1:0] = enable_q;
		end else if (s_axi_araddr == `PCM_ADDR_MEMORY_CONTROL) begin
			rd_val[`PCM_MEM_SLEEP_BIT] = mem_sleep_q;
		end
	end
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= `PCM_RST_ZERO;
			s_axi_rresp <= `PCM_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_val;
			s_axi_rresp <= mapped(s_axi_araddr) ? `PCM_RESP_OKAY : `PCM_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Checks
	a_timer_held_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		!pc_q[`PCM_PC_TIMER_EN] |=> timer_q == 4'h0) else $error("timer not held"); // RULE3
	a_timer_step_tick: assert property (@(posedge aclk) disable iff (!aresetn)
		pc_q[`PCM_PC_TIMER_EN] && $past(pc_q[`PCM_PC_TIMER_EN]) && timer_q != $past(timer_q)
		|-> $past(tick_8ms) && timer_q == $past(timer_q) + 4'h1) else $error("timer step wrong"); // RULE4
	a_timer_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
		match && !match_q |=> flags_q[pcm_pkg::FLAG_WAKE_TIMER]) else $error("timer flag missed"); // RULE5
	a_flag_sticky_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		flags_q[pcm_pkg::FLAG_IRQ_RISE] && !wr_flags |=> flags_q[pcm_pkg::FLAG_IRQ_RISE])
		else $error("flag dropped"); // RULE24
	a_good_fall_flag: assert property (@(posedge aclk) disable iff (!aresetn)
		$fell(pins.power_good) |=> flags_q[pcm_pkg::FLAG_GOOD_FALL]) else $error("good fall missed"); // RULE7
	a_power_up_both: assert property (@(posedge aclk) disable iff (!aresetn)
		power_up |=> supply_enable_out && core_supply_rail && pc_q[`PCM_PC_CUTOFF_PEND])
		else $error("power up incomplete"); // RULE13
	a_cutoff_drops_supply: assert property (@(posedge aclk) disable iff (!aresetn)
		cutoff && !power_up |=> !supply_enable_out && pc_q[`PCM_PC_CUTOFF_OCC]) else $error("cutoff failed"); // RULE14
	a_pending_keeps_supply: assert property (@(posedge aclk) disable iff (!aresetn)
		pend_any && core_supply_rail && !cutoff |=> core_supply_rail) else $error("supply dropped"); // RULE22
	a_halt_cleared_wake: assert property (@(posedge aclk) disable iff (!aresetn)
		wake_now |=> !pc_q[`PCM_PC_HALT]) else $error("halt not cleared"); // RULE18
	a_clock_gated_start: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(core_supply_rail) && !pc_q[`PCM_PC_BYPASS] |-> !clocks.sys_clock_en)
		else $error("clock not gated"); // RULE16
	a_sleep_cleared_access: assert property (@(posedge aclk) disable iff (!aresetn)
		external_access |=> !memory_sleep_request) else $error("sleep not cleared"); // RULE2
endmodule
`default_nettype wire

//--- sim/pcm_supply_model.sv
`timescale 1ns/1ns
`default_nettype none
module pcm_supply_model (
	input wire logic aclk,
	input wire logic supply_enable_out,
	input wire logic button_cmd,
	input wire logic irq_cmd,
	input wire logic good_cmd,
	input wire logic sag_cmd,
	output pcm_pkg::pcm_pins_t pins
);
	initial pins = '0;
	// Pins change just after an edge, so they stay synchronous to aclk
	always @(posedge aclk) begin
		pins.on_button <= button_cmd;
		pins.power_irq_pin <= irq_cmd;
		// A weak battery loses its good level once the supply is switched on
		pins.power_good <= good_cmd && !(sag_cmd && supply_enable_out);
	end
endmodule
`default_nettype wire

//--- sim/pcm_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "pcm_regs.svh"
module pcm_top_tb;
	localparam logic [11:0] pc_addr = `PCM_ADDR_POWER_CONTROL;
	localparam logic [11:0] flag_addr = `PCM_ADDR_EVENT_FLAGS;
	localparam logic [11:0] wake_addr = `PCM_ADDR_WAKE_ENABLE;
	localparam logic [11:0] mem_addr = `PCM_ADDR_MEMORY_CONTROL;
	localparam logic [1:0] okay = `PCM_RESP_OKAY;
	localparam logic [1:0] slverr = `PCM_RESP_SLVERR;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [11:0] s_axi_awaddr = 12'h0;
	logic s_axi_awvalid = 1'h0;
	logic s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_wvalid = 1'h0;
	logic s_axi_wready;
	logic [1:0] s_axi_bresp;
	logic s_axi_bvalid;
	logic s_axi_bready = 1'h1;
	logic [11:0] s_axi_araddr = 12'h0;
	logic s_axi_arvalid = 1'h0;
	logic s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic s_axi_rvalid;
	logic s_axi_rready = 1'h1;
	pcm_pkg::pcm_pins_t pins;
	logic tick_2ms = 1'h0;
	logic tick_8ms = 1'h0;
	logic video_master_clock = 1'h0;
	logic external_access = 1'h0;
	pcm_pkg::pcm_clk_t clocks;
	logic supply_enable_out;
	logic core_supply_rail;
	logic memory_sleep_request;
	logic button_cmd = 1'h0;
	logic irq_cmd = 1'h0;
	logic good_cmd = 1'h0;
	logic sag_cmd = 1'h0;
	int failures = 0;
	int samples_checked = 0;
	int cycles = 0;

	pcm_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pins,
		.tick_2ms, .tick_8ms, .video_master_clock, .external_access, .clocks, .supply_enable_out,
		.core_supply_rail, .memory_sleep_request);

	pcm_supply_model partner (.aclk, .supply_enable_out, .button_cmd, .irq_cmd, .good_cmd, .sag_cmd, .pins);

	always #5 aclk = ~aclk;

	always @(posedge aclk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			end_sim();
		end
	end

	task automatic end_sim;
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge aclk);
	endtask

	// Address and data offered together, each released at its own acceptance edge
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'h1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		d = s_axi_rdata;
		chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
	endtask

	task automatic rc(input string n, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] d;
		rd(a, d, okay);
		chk(n, e, d & m);
	endtask

	task automatic supply(input logic [1:0] e);
		chk("supply", {30'h0, e}, {30'h0, supply_enable_out, core_supply_rail});
	endtask

	task automatic pulse_2ms;
		tick_2ms <= 1'h1;
		@(posedge aclk);
		tick_2ms <= 1'h0;
		idle(2);
	endtask

	// Counts the cycles in which one bit of the clock-enable struct is high
	task automatic count_clk(input int b, input int n, output logic [31:0] c);
		c = 32'h0000_0000;
		repeat (n) begin
			@(posedge aclk);
			c = c + 32'(clocks[b]);
		end
	endtask

	task automatic pulse_8ms;
		tick_8ms <= 1'h1;
		@(posedge aclk);
		tick_8ms <= 1'h0;
		idle(2);
	endtask

	task automatic t_reset;
		logic [31:0] d;
		rc("reset value", pc_addr, 32'hffff_ffff, 32'h0000_0004);
		rd(12'h1e0, d, slverr);
		chk("unmapped data", 32'h0000_0000, d);
		wr(12'h1e0, 32'hffff_ffff, slverr);
	endtask

	task automatic t_pins;
		good_cmd <= 1'h1;
		irq_cmd <= 1'h1;
		idle(4);
		rc("live pins", pc_addr, 32'hffff_ffff, 32'h6000_0004);
		rc("rise flags", flag_addr, 32'hffff_ffff, 32'h0000_000a);
		irq_cmd <= 1'h0;
		idle(4);
		rc("fall flag", flag_addr, 32'hffff_ffff, 32'h0000_000e);
		wr(flag_addr, 32'h0000_000e, okay);
		wr(pc_addr, 32'he000_0004, okay);
		rc("read only", pc_addr, 32'hffff_ffff, 32'h2000_0004);
		rc("flags cleared", flag_addr, 32'hffff_ffff, 32'h0000_0000);
	endtask

	task automatic t_power;
		wr(pc_addr, 32'h0000_0424, okay);
		button_cmd <= 1'h1;
		idle(6);
		supply(2'h3);
		chk("sys clock", 32'h1, {31'h0, clocks.sys_clock_en});
		rc("pending set", pc_addr, 32'hffff_ffff, 32'ha000_0627);
		button_cmd <= 1'h0;
		sag_cmd <= 1'h1;
		idle(6);
		supply(2'h0);
		rc("cutoff seen", pc_addr, 32'h0000_0100, 32'h0000_0100);
		sag_cmd <= 1'h0;
		wr(pc_addr, 32'h0000_0004, okay);
		rc("cutoff cleared", pc_addr, 32'h0000_0100, 32'h0000_0000);
	endtask

	task automatic t_timer;
		wr(flag_addr, 32'h0000_007f, okay);
		wr(wake_addr, 32'h0000_0001, okay);
		wr(pc_addr, 32'h0000_3834, okay);
		pulse_8ms();
		pulse_8ms();
		rc("timer early", flag_addr, 32'h0000_0001, 32'h0000_0000);
		supply(2'h0);
		pulse_8ms();
		idle(2);
		rc("timer match", flag_addr, 32'h0000_0001, 32'h0000_0001);
		supply(2'h3);
		rc("halt cleared", pc_addr, 32'h0000_0013, 32'h0000_0003);
		wr(pc_addr, 32'h0000_3830, okay);
		rc("supply held", pc_addr, 32'h0000_0003, 32'h0000_0003);
		wr(flag_addr, 32'h0000_0001, okay);
		wr(pc_addr, 32'h0000_0004, okay);
		idle(2);
		supply(2'h0);
	endtask

	task automatic t_memory;
		wr(mem_addr, 32'h0000_0001, okay);
		idle(1);
		chk("sleep set", 32'h1, {31'h0, memory_sleep_request});
		external_access <= 1'h1;
		@(posedge aclk);
		external_access <= 1'h0;
		idle(2);
		chk("sleep cleared", 32'h0, {31'h0, memory_sleep_request});
		rc("sleep bit", mem_addr, 32'h0000_0001, 32'h0000_0000);
	endtask

	task automatic t_clocks;
		logic [31:0] c;
		wr(pc_addr, 32'h0000_0084, okay);
		button_cmd <= 1'h1;
		idle(6);
		supply(2'h3);
		chk("short settle gated", 32'h0, {31'h0, clocks.sys_clock_en});
		pulse_2ms();
		pulse_2ms();
		chk("short settle early", 32'h0, {31'h0, clocks.sys_clock_en});
		pulse_2ms();
		chk("short settle done", 32'h1, {31'h0, clocks.sys_clock_en});
		wr(pc_addr, 32'h0400_0087, okay);
		count_clk(2, 4, c);
		chk("bus half", 32'h0000_0002, c);
		count_clk(3, 4, c);
		chk("core half", 32'h0000_0002, c);
		wr(pc_addr, 32'h1200_0097, okay);
		count_clk(3, 4, c);
		chk("core halted", 32'h0000_0000, c);
		count_clk(2, 4, c);
		chk("bus full", 32'h0000_0004, c);
		chk("decouple", 32'h1, {31'h0, clocks.peripheral_clock_decouple});
		video_master_clock <= 1'h1;
		idle(1);
		count_clk(1, 16, c);
		video_master_clock <= 1'h0;
		chk("video quarter", 32'h0000_0004, c);
	endtask

	task automatic t_debounce;
		wr(pc_addr, 32'h0000_000c, okay);
		wr(flag_addr, 32'h0000_007f, okay);
		button_cmd <= 1'h0;
		idle(3);
		pulse_8ms();
		pulse_8ms();
		rc("debounce early", flag_addr, 32'h0000_0040, 32'h0000_0000);
		pulse_8ms();
		rc("debounce done", flag_addr, 32'h0000_0040, 32'h0000_0040);
		wr(wake_addr, 32'h0000_0002, okay);
		good_cmd <= 1'h0;
		idle(2);
		irq_cmd <= 1'h1;
		idle(4);
		supply(2'h0);
		rc("latched flag", flag_addr, 32'h0000_0002, 32'h0000_0002);
		good_cmd <= 1'h1;
		idle(4);
		supply(2'h3);
		chk("long settle gated", 32'h0, {31'h0, clocks.sys_clock_en});
		pulse_8ms();
		pulse_8ms();
		chk("long settle early", 32'h0, {31'h0, clocks.sys_clock_en});
		pulse_8ms();
		chk("long settle done", 32'h1, {31'h0, clocks.sys_clock_en});
	endtask

	initial begin
		idle(2);
		aresetn <= 1'h1;
		t_reset();
		t_pins();
		t_power();
		t_timer();
		t_memory();
		t_clocks();
		t_debounce();
		end_sim();
	end
endmodule
`default_nettype wire
